// ---- rtl/apcp_pkg.sv ----
package apcp_pkg;
  // Result and core widths
  localparam int SAMPLE_W = 12;
  localparam int STAGES = 15;
  localparam int ANALOG_W = 17;
  localparam int SUM_W = 16;
  // Full scale of the stand-in analog value equals the reference level
  localparam logic signed [16:0] ANALOG_REF = 17'sh08000;
  localparam logic [14:0] ANALOG_MAX = 15'h7fff;
  // Correction drops this many fraction bits from the weighted sum
  localparam int FRAC_BITS = 3;
  // Calibrate request must be high this many cycles
  localparam int CAL_HOLD = 3;
  // Calibration and power-down exit lengths, in conversion clock cycles
  localparam int CAL_CYCLES = 4000;
  localparam int WAKE_CYCLES = 4000;
  localparam int CNT_W = 12;
  // Analog stage latency plus the output register
  localparam int PIPE_LAT = STAGES + 1;
  localparam int LAT_W = 5;
  // Host clock and the settle time before the first requested calibration
  localparam int CLK_HZ = 10_000_000;
  localparam int POWERUP_WAIT_S = 10;
  localparam longint POWERUP_WAIT_CYC = longint'(POWERUP_WAIT_S) * longint'(CLK_HZ);
  localparam int WAIT_W = 27;
  // Host register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SAMPLE = 8'h08;
  // Control fields
  localparam int CTRL_CAL_GO = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_OUT_EN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Status fields
  localparam int STAT_READY = 0;
  localparam int STAT_OOR = 1;
  localparam int STAT_CAL_BUSY = 2;
  localparam int STAT_NEW = 3;
  // Device control states
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_CAL = 4'h2,
    ST_SLEEP = 4'h4,
    ST_WAKE = 4'h8
  } apcp_state_e;
endpackage

// ---- rtl/apcp_link_if.sv ----
interface apcp_link_if;
  logic calibrate; // Level calibrate request
  logic power_down_request; // High holds the converter asleep
  logic output_enable_n; // Low lets the data buffers drive
  logic [apcp_pkg::SAMPLE_W-1:0] sample_word; // Result word
  logic sample_drive; // High while the device drives sample_word
  logic out_of_range; // Result came from an out-of-range input
  logic ready; // Converter operating normally
  modport dev (
    input calibrate, power_down_request, output_enable_n,
    output sample_word, sample_drive, out_of_range, ready
  );
  modport host (
    output calibrate, power_down_request, output_enable_n,
    input sample_word, sample_drive, out_of_range, ready
  );
endinterface

// ---- rtl/apcp_hold_detect.sv ----
module apcp_hold_detect #(
  parameter int HOLD = apcp_pkg::CAL_HOLD
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Request level and its qualified start
  input wire logic level_i,
  output logic start_o
);
  // Run length of the high level, saturating at HOLD
  logic [3:0] run_q;

  if (HOLD < 1 || HOLD > 15)
  begin : g_chk
    $error("apcp_hold_detect: HOLD out of range");
  end

  // Count consecutive high cycles; any low cycle restarts the count
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || !level_i)
      run_q <= 4'h0;
    else if (run_q != 4'(HOLD))
      run_q <= run_q + 4'h1;
  end

  // One pulse on the cycle the level has been high HOLD cycles
  assign start_o = level_i && (run_q == 4'(HOLD - 1));
endmodule

// ---- rtl/apcp_device.sv ----
// Overview of operation
// - Calibrate after power-on and on request
// - Calibrate level held three cycles starts calibration
// - Calibration lasts 4000 conversion clock cycles
// - Host discards words seen during calibration
// - Host calibrates at its conversion clock rate
// - Host calibrates ten seconds after power-up
// - Output enable low drives the data buffers
// - Output enable high floats the data buffers
// - Power-down request high: sleep, no conversions
// - Resume within exit interval after request falls
// - Pipeline contents lost on entering power-down
// - Host recalibrates after every power-down cycle
// - Ready high only in normal operation
// - Out-of-range flag marks input outside range
// - Results are 12-bit straight binary words
// - New result every clock after fixed latency
// - Host clock stable, 0.5 to 5 MHz; CLK_HZ here and the bench clock are 10 MHz
// - Fifteen one-bit stages, correction forms result
// - Calibration stores per-bit coefficients, conversions use
// - Ready falls within 3 cycles of calibrate
// - Ready falls within 3 cycles of power-down
// - Power-down exit takes 4000 cycles
//
// Chosen here: the address-and-strobe port and the register addresses.
module apcp_device #(
  parameter int CAL_CYCLES = apcp_pkg::CAL_CYCLES,
  parameter int WAKE_CYCLES = apcp_pkg::WAKE_CYCLES,
  parameter int CAL_HOLD = apcp_pkg::CAL_HOLD
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Link to the host
  apcp_link_if.dev link,
  // Sampled input, in units where the reference level is full scale
  input wire logic signed [apcp_pkg::ANALOG_W-1:0] analog_i
);
  localparam int S = apcp_pkg::STAGES;
  localparam int CW = apcp_pkg::CNT_W;
  localparam int SW = apcp_pkg::SAMPLE_W;

  if (CAL_CYCLES < S || CAL_CYCLES >= (1 << CW) || WAKE_CYCLES < 1
      || WAKE_CYCLES >= (1 << CW))
  begin : g_chk
    $error("apcp_device: cycle counts do not fit the counter");
  end

  // Nominal weight of stage k, most significant stage first
  function automatic logic [S-1:0] stage_weight(input int k);
    stage_weight = S'(1) << (S - 1 - k);
  endfunction

  // Weighted sum of the raw stage bits, saturated to the result width
  function automatic logic [SW-1:0] correct(
    input logic [S-1:0] raw,
    input logic [S-1:0] coef [S]
  );
    logic [apcp_pkg::SUM_W-1:0] sum;
    sum = '0;
    for (int k = 0; k < S; k++)
      if (raw[S-1-k])
        sum = sum + apcp_pkg::SUM_W'(coef[k]);
    if (sum[apcp_pkg::SUM_W-1])
      correct = '1;
    else
      correct = sum[S-1:apcp_pkg::FRAC_BITS];
  endfunction

  // Control state and cycle counter
  apcp_pkg::apcp_state_e state_q, state_d;
  logic [CW-1:0] cnt_q;
  // Qualified calibrate start from the level filter
  logic cal_start;
  // Per-stage residue, raw bits gathered so far, out-of-range tag
  logic [S-1:0] res_q [S];
  logic [S-1:0] raw_q [S];
  logic oor_pipe_q [S];
  // Correction coefficients written by calibration
  logic [S-1:0] coef_q [S];
  // Link output flops
  logic [SW-1:0] word_q;
  logic drive_q;
  logic oor_q;
  logic ready_q;
  // Clipped input and its range flag
  logic [S-1:0] in_clip;
  logic in_oor;

  apcp_hold_detect #(
    .HOLD(CAL_HOLD)
  ) u_cal_detect (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .level_i(link.calibrate),
    .start_o(cal_start)
  );

  // Next state; power-down outranks everything else
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      apcp_pkg::ST_RUN:
      begin
        if (link.power_down_request)
          state_d = apcp_pkg::ST_SLEEP;
        else if (cal_start)
          state_d = apcp_pkg::ST_CAL;
      end
      apcp_pkg::ST_CAL:
      begin
        if (link.power_down_request)
          state_d = apcp_pkg::ST_SLEEP;
        else if (cnt_q == CW'(CAL_CYCLES - 1))
          state_d = apcp_pkg::ST_RUN;
      end
      apcp_pkg::ST_SLEEP:
      begin
        // Stays asleep for as long as the request is high
        if (!link.power_down_request)
          state_d = apcp_pkg::ST_WAKE;
      end
      apcp_pkg::ST_WAKE:
      begin
        if (link.power_down_request)
          state_d = apcp_pkg::ST_SLEEP;
        else if (cnt_q == CW'(WAKE_CYCLES - 1))
          state_d = apcp_pkg::ST_RUN;
      end
      default:
        state_d = apcp_pkg::ST_CAL;
    endcase
  end

  // State register; reset stands for power-on and starts calibration
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      state_q <= apcp_pkg::ST_CAL;
    else
      state_q <= state_d;
  end

  // Counter restarts on every state change
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || state_d != state_q)
      cnt_q <= '0;
    else if (state_q == apcp_pkg::ST_CAL || state_q == apcp_pkg::ST_WAKE)
      cnt_q <= cnt_q + CW'(1);
  end

  // Calibration derives one coefficient per stage bit in its first cycles
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      for (int k = 0; k < S; k++)
        coef_q[k] <= '0;
    end
    else if (state_q == apcp_pkg::ST_CAL && cnt_q < CW'(S))
    begin
      for (int k = 0; k < S; k++)
        if (cnt_q == CW'(k))
          coef_q[k] <= stage_weight(k);
    end
  end

  // Input clip and range check against ground and the reference
  always_comb
  begin
    in_oor = (analog_i < 0) || (analog_i > apcp_pkg::ANALOG_REF);
    if (analog_i < 0)
      in_clip = '0;
    else if (analog_i >= apcp_pkg::ANALOG_REF)
      in_clip = apcp_pkg::ANALOG_MAX;
    else
      in_clip = analog_i[S-1:0];
  end

  // Fifteen stages: each doubles its residue and emits the carry bit.
  // Asleep the core is cleared and held, so old samples cannot leak out.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || state_q == apcp_pkg::ST_SLEEP)
    begin
      for (int k = 0; k < S; k++)
      begin
        res_q[k] <= '0;
        raw_q[k] <= '0;
        oor_pipe_q[k] <= 1'b0;
      end
    end
    else
    begin
      // Calibration drives the core with a fixed level, not the input
      res_q[0] <= (state_q == apcp_pkg::ST_CAL) ? '0 : (in_clip << 1);
      raw_q[0] <= (state_q == apcp_pkg::ST_CAL) ? '0 : {in_clip[S-1], {(S-1){1'b0}}};
      oor_pipe_q[0] <= in_oor && (state_q != apcp_pkg::ST_CAL);
      for (int k = 1; k < S; k++)
      begin
        res_q[k] <= res_q[k-1] << 1;
        raw_q[k] <= raw_q[k-1] | (S'(res_q[k-1][S-1]) << (S - 1 - k));
        oor_pipe_q[k] <= oor_pipe_q[k-1];
      end
    end
  end

  // Corrected result every clock, straight binary
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      word_q <= '0;
      oor_q <= 1'b0;
    end
    else
    begin
      word_q <= correct(raw_q[S-1], coef_q);
      oor_q <= oor_pipe_q[S-1];
    end
  end

  // Buffer enable follows the active-low enable, one flop behind
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      drive_q <= 1'b0;
    else
      drive_q <= !link.output_enable_n;
  end

  // Ready follows the next state so it falls on the same edge
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      ready_q <= 1'b0;
    else
      ready_q <= (state_d == apcp_pkg::ST_RUN);
  end

  assign link.sample_word = word_q;
  assign link.sample_drive = drive_q;
  assign link.out_of_range = oor_q;
  assign link.ready = ready_q;
endmodule

// ---- rtl/apcp_host.sv ----
module apcp_host #(
  parameter int CAL_HOLD = apcp_pkg::CAL_HOLD,
  parameter longint POWERUP_WAIT = apcp_pkg::POWERUP_WAIT_CYC,
  parameter int PIPE_LAT = apcp_pkg::PIPE_LAT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Link to the converter
  apcp_link_if.host link,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Captured result stream
  output logic [apcp_pkg::SAMPLE_W-1:0] sample_o,
  output logic sample_valid_o
);
  localparam int WW = apcp_pkg::WAIT_W;
  localparam int LW = apcp_pkg::LAT_W;

  if (CAL_HOLD < 1 || CAL_HOLD > 15 || POWERUP_WAIT < 1
      || POWERUP_WAIT >= (64'h1 << WW) || PIPE_LAT < 1 || PIPE_LAT >= (1 << LW))
  begin : g_chk
    $error("apcp_host: parameter out of range");
  end

  // Register state
  logic [2:0] ctrl_q;
  logic [31:0] rdata_q;
  logic new_q;
  // Request generation
  logic [WW-1:0] wait_q;
  logic wait_done_q;
  logic [3:0] hold_q;
  logic pend_cal_q;
  logic sleep_was_q;
  // Capture path
  logic ready_was_q;
  logic [LW-1:0] skip_q;
  logic [apcp_pkg::SAMPLE_W-1:0] sample_q;
  logic valid_q;
  logic oor_q;
  logic cal_go;
  logic capture;

  assign cal_go = wr_i && addr_i == apcp_pkg::REG_CTRL && wdata_i[apcp_pkg::CTRL_CAL_GO];
  // Good word: ready, skip window over, buffers driving
  assign capture = link.ready && skip_q == '0 && link.sample_drive;

  // Control register; the go bit is a trigger and is not stored
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      ctrl_q <= apcp_pkg::CTRL_RESET;
    else if (wr_i && addr_i == apcp_pkg::REG_CTRL)
      ctrl_q <= {wdata_i[apcp_pkg::CTRL_OUT_EN], wdata_i[apcp_pkg::CTRL_SLEEP], 1'b0};
  end

  // Settle timer for the first calibration after power-up
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      wait_q <= '0;
      wait_done_q <= 1'b0;
    end
    else if (!wait_done_q)
    begin
      wait_q <= wait_q + WW'(1);
      wait_done_q <= (wait_q == WW'(POWERUP_WAIT - 1));
    end
  end

  // Pending calibration: settle timer, software, or end of a sleep
  always_ff @(posedge ref_clk_i)
  begin
    sleep_was_q <= reset_i ? 1'b0 : ctrl_q[apcp_pkg::CTRL_SLEEP];
    if (reset_i)
      pend_cal_q <= 1'b0;
    else if ((!wait_done_q && wait_q == WW'(POWERUP_WAIT - 1)) || cal_go)
      pend_cal_q <= 1'b1;
    else if (sleep_was_q && !ctrl_q[apcp_pkg::CTRL_SLEEP])
      pend_cal_q <= 1'b1;
    else if (hold_q == 4'(CAL_HOLD))
      pend_cal_q <= 1'b0;
  end

  // Calibrate held high CAL_HOLD cycles, issued only once ready;
  // this clock is the one later used for conversions
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      hold_q <= 4'h0;
    else if (hold_q != 4'h0)
      hold_q <= (hold_q == 4'(CAL_HOLD)) ? 4'h0 : hold_q + 4'h1;
    else if (pend_cal_q && link.ready)
      hold_q <= 4'h1;
  end

  // Skip the words still in the pipeline when ready rises
  always_ff @(posedge ref_clk_i)
  begin
    ready_was_q <= reset_i ? 1'b0 : link.ready;
    if (reset_i || !link.ready)
      skip_q <= LW'(PIPE_LAT);
    else if (skip_q != '0 && ready_was_q)
      skip_q <= skip_q - LW'(1);
  end

  // Capture register and stream output
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      sample_q <= '0;
      valid_q <= 1'b0;
      oor_q <= 1'b0;
    end
    else
    begin
      valid_q <= capture;
      if (capture)
      begin
        sample_q <= link.sample_word;
        oor_q <= link.out_of_range;
      end
    end
  end

  // New-sample flag; a capture in the clearing read wins
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      new_q <= 1'b0;
    else if (capture)
      new_q <= 1'b1;
    else if (rd_i && addr_i == apcp_pkg::REG_SAMPLE)
      new_q <= 1'b0;
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || !rd_i)
      rdata_q <= '0;
    else
    begin
      case (addr_i)
        apcp_pkg::REG_CTRL:
          rdata_q <= {29'h0, ctrl_q};
        apcp_pkg::REG_STATUS:
          rdata_q <= {28'h0, new_q, hold_q != 4'h0, oor_q, link.ready};
        apcp_pkg::REG_SAMPLE:
          rdata_q <= {20'h0, sample_q};
        default:
          rdata_q <= '0;
      endcase
    end
  end

  assign link.calibrate = hold_q != 4'h0;
  assign link.power_down_request = ctrl_q[apcp_pkg::CTRL_SLEEP];
  assign link.output_enable_n = !ctrl_q[apcp_pkg::CTRL_OUT_EN];
  assign rdata_o = rdata_q;
  assign sample_o = sample_q;
  assign sample_valid_o = valid_q;
endmodule

// ---- verif/apcp_link_checker.sv ----
module apcp_link_checker #(
  parameter int CAL_CYCLES = apcp_pkg::CAL_CYCLES,
  parameter int WAKE_CYCLES = apcp_pkg::WAKE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Link signals
  input wire logic calibrate,
  input wire logic power_down_request,
  input wire logic output_enable_n,
  input wire logic [apcp_pkg::SAMPLE_W-1:0] sample_word,
  input wire logic sample_drive,
  input wire logic out_of_range,
  input wire logic ready
);
  // Slack for the registered wake exit
  localparam int WAKE_MAX = WAKE_CYCLES + 3;
  logic [15:0] cal_cnt_q; // Low cycles of ready
  logic cal_trk_q; // Low phase opened by a calibrate request
  logic [15:0] wake_cnt_q; // Low cycles since sleep released
  logic wake_trk_q; // Low phase held a sleep

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // Measure each low phase of ready; a sleep spoils the calibration count
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || ready)
    begin
      cal_cnt_q <= 16'h0000;
      cal_trk_q <= 1'b0;
      wake_cnt_q <= 16'h0000;
      wake_trk_q <= 1'b0;
    end
    else
    begin
      cal_cnt_q <= cal_cnt_q + 16'h0001;
      if (power_down_request)
        cal_trk_q <= 1'b0;
      else if (cal_cnt_q == 16'h0000)
        cal_trk_q <= $past(calibrate);
      wake_cnt_q <= power_down_request ? 16'h0000 : wake_cnt_q + 16'h0001;
      wake_trk_q <= wake_trk_q | power_down_request;
    end
  end

  cal_ready_fall_a: assert property (
    (ready && calibrate && !power_down_request)[*3] |=> !ready)
    else $error("ready did not fall after calibrate");
  cal_length_a: assert property (
    $rose(ready) && cal_trk_q |-> cal_cnt_q == CAL_CYCLES)
    else $error("calibration length wrong");
  wake_length_a: assert property (
    $rose(ready) && wake_trk_q |-> wake_cnt_q >= WAKE_CYCLES && wake_cnt_q <= WAKE_MAX)
    else $error("wake length wrong");
  wake_bound_a: assert property (
    wake_trk_q && !power_down_request |-> wake_cnt_q <= WAKE_MAX)
    else $error("no wake after sleep");
  sleep_ready_a: assert property (
    power_down_request |=> !ready)
    else $error("ready high in sleep");
  oe_drive_a: assert property (
    !output_enable_n |=> sample_drive)
    else $error("buffers not driven");
  oe_float_a: assert property (
    output_enable_n |=> !sample_drive)
    else $error("buffers not floated");
  sleep_word_a: assert property (
    power_down_request[*4] |-> sample_word == 12'h000)
    else $error("pipeline kept in sleep");
endmodule

// ---- verif/test_pipelined_adc_control_port.sv ----
module test_pipelined_adc_control_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CAL = 40; // Short counts keep the run brief
  localparam int WAKE = 40;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h00000000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [11:0] sample_o;
  logic sample_valid_o;
  logic signed [16:0] analog_i = 17'sh00000;
  logic [31:0] d;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 46129;
  int v;
  int k;
  int corner [5] = '{0, 32767, 32768, -8, 40000}; // Range edges
  apcp_link_if link ();
  apcp_link_if link_b (); // Second device, driven by the bench

  // Steady, jitter-free conversion clock; its rate is fixed by the bench
  always #50 ref_clk_i = ~ref_clk_i;

  apcp_device #(.CAL_CYCLES(CAL), .WAKE_CYCLES(WAKE)) i_apcp_device (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .link(link), .analog_i(analog_i));
  apcp_device #(.CAL_CYCLES(CAL), .WAKE_CYCLES(WAKE)) i_apcp_device_b (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .link(link_b), .analog_i(analog_i));
  apcp_host #(.POWERUP_WAIT(64'd20)) i_apcp_host (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .link(link), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sample_o(sample_o), .sample_valid_o(sample_valid_o));
  apcp_link_checker #(.CAL_CYCLES(CAL), .WAKE_CYCLES(WAKE)) i_apcp_link_checker (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .calibrate(link.calibrate),
    .power_down_request(link.power_down_request), .output_enable_n(link.output_enable_n),
    .sample_word(link.sample_word), .sample_drive(link.sample_drive),
    .out_of_range(link.out_of_range), .ready(link.ready));

  // Expected word: input scaled so the reference maps past the top code
  function automatic logic [11:0] exp_word(input int a);
    return 12'(a >> 3);
  endfunction

  // Expected range flag
  function automatic logic exp_oor(input int a);
    return (a < 0) || (a > 32768);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("TB: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= w;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
  endtask

  // Ready must settle high; the host may calibrate on its own first
  task automatic wait_idle();
    k = 0;
    for (int i = 0; i < 400 && k < 24; i++)
    begin
      @(negedge ref_clk_i);
      k = link.ready ? k + 1 : 0;
    end
    check("settle", k, 24);
  endtask

  // Count the cycles of the next low phase of ready, bounded
  task automatic low_len();
    k = 0;
    for (int i = 0; i < 10 && link.ready; i++)
      @(negedge ref_clk_i);
    while (!link.ready && k < 200)
    begin
      @(negedge ref_clk_i);
      k++;
    end
  endtask

  task automatic pulse_b(input int w);
    @(posedge ref_clk_i);
    link_b.calibrate <= 1'b1;
    repeat (w) @(posedge ref_clk_i);
    link_b.calibrate <= 1'b0;
  endtask

  // Hang guard
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    link_b.calibrate <= 1'b0;
    link_b.power_down_request <= 1'b0;
    link_b.output_enable_n <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    // Power-on calibration holds ready low for exactly its length
    repeat (CAL - 1) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("power-on cal", link_b.ready, 1'b0);
    @(negedge ref_clk_i);
    check("power-on end", link_b.ready, 1'b1);
    wait_idle();
    $display("TB: start-up done");
    reg_wr(8'h00, 32'h00000004);
    reg_rd(8'h04);
    check("status", d & 32'h7, 32'h1);
    reg_rd(8'h0c);
    check("unmapped", d, 32'h0);
    check("drive on", link.sample_drive, 1'b1);
    // Corners first, then random in-range inputs
    for (int i = 0; i < 10; i++)
    begin
      v = (i < 5) ? corner[i] : ($random(seed) & 32'h7fff);
      @(posedge ref_clk_i);
      analog_i <= v[16:0];
      repeat (apcp_pkg::PIPE_LAT + 4) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check("range flag", link.out_of_range, exp_oor(v));
      check("stream valid", sample_valid_o, 1'b1);
      if (v >= 0 && v < 32768)
      begin
        check("word", link.sample_word, exp_word(v));
        check("stream", sample_o, exp_word(v));
        reg_rd(8'h08);
        check("captured", d[11:0], exp_word(v));
      end
      reg_rd(8'h04);
      check("oor status", d[1], exp_oor(v));
    end
    // Old word stands until the pipeline delay has passed, then the new one
    @(posedge ref_clk_i);
    analog_i <= 17'sh00800;
    repeat (apcp_pkg::PIPE_LAT - 1) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("latency old", link.sample_word, exp_word(v));
    @(negedge ref_clk_i);
    check("latency new", link.sample_word, exp_word(32'h800));
    $display("TB: data path done");
    reg_wr(8'h00, 32'h00000000);
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("drive off", link.sample_drive, 1'b0);
    reg_wr(8'h00, 32'h00000005);
    low_len();
    check("cal length", k, CAL);
    wait_idle();
    $display("TB: calibration done");
    reg_wr(8'h00, 32'h00000006);
    repeat (10) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("asleep", {link.ready, link.sample_word}, 32'h0);
    check("no capture", sample_valid_o, 1'b0);
    reg_wr(8'h00, 32'h00000004);
    low_len();
    check("wake", k >= WAKE && k <= WAKE + 4, 1'b1);
    wait_idle();
    $display("TB: power-down done");
    pulse_b(2);
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("short pulse", link_b.ready, 1'b1);
    pulse_b(3);
    @(negedge ref_clk_i);
    check("cal start", link_b.ready, 1'b0);
    $display("TB: request width done");
    tally_and_finish();
  end
endmodule
